/* File: design/fault_margin_select.sv */
// fault output routing and margin bank select with AXI4-Lite registers
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "fault_margin_consts.svh"
module fault_margin_select
   import fault_margin_pkg::*;
(
   // clock and reset
   input  wire logic          clk_in,
   input  wire logic          arst_n_in,
   // axi write address / data / response
   input  wire logic [7:0]    awaddr_in,
   input  wire logic          awvalid_in,
   output logic               awready_out,
   input  wire logic [31:0]   wdata_in,
   input  wire logic [3:0]    wstrb_in,
   input  wire logic          wvalid_in,
   output logic               wready_out,
   output logic [1:0]         bresp_out,
   output logic               bvalid_out,
   input  wire logic          bready_in,
   // axi read address / data
   input  wire logic [7:0]    araddr_in,
   input  wire logic          arvalid_in,
   output logic               arready_out,
   output logic [31:0]        rdata_out,
   output logic [1:0]         rresp_out,
   output logic               rvalid_out,
   input  wire logic          rready_in,
   // threshold violations per monitored input, from comparators
   input  wire logic [11:0]   ov_viol_in,
   input  wire logic [11:0]   uv_viol_in,
   input  wire logic [11:0]   ew_viol_in,
   // sequencing fault, from the sequencer
   input  wire logic          seq_fault_in,
   // margin pins
   input  wire logic          shared_pin_2_in,
   input  wire logic          shared_pin_3_in,
   // fault outputs
   output logic               fault_out_a_out,
   output logic               fault_out_b_out,
   output logic               powerup_fault_flag_out,
   output logic               powerup_fault_oe_n_out,
   output logic               supply_disable_out,
   output logic               fault_store_out,
   // dac control
   output dac_bank_t          dac_bank_out,
   output logic               dac_switch_force_out,
   output logic               margin_active_out,
   output logic               log_inhibit_out,
   // interrupt
   output logic               irq_out
);

   //==========================================================
   // helpers
   // one output's raw fault: any selected input with any enabled class
   function automatic logic fault_hit(input logic [7:0] sel,
                                      input logic [7:0] ctl,
                                      input logic [11:0] ov,
                                      input logic [11:0] uv,
                                      input logic [11:0] ew);
      logic [11:0] mask;
      logic [11:0] viol;
      mask = {ctl[`CTL_UPPER_MSB:0], sel};               // R1 R2 R5 R6
      viol = (ov & {12{ctl[`CTL_OV_BIT]}})               // R3 R7
           | (uv & {12{ctl[`CTL_UV_BIT]}})
           | (ew & {12{ctl[`CTL_EW_BIT]}});
      return |(mask & viol);                             // R8 R17
   endfunction

   // drive the asserted or idle pin level from polarity
   function automatic logic pol_level(input logic act, input logic pol);
      return pol ? act : ~act;                           // R4
   endfunction

   //==========================================================
   // registers
   logic [7:0]  fa_sel_ff, fa_ctl_ff, fb_sel_ff, fb_ctl_ff, mode_ff;
   logic [3:0]  status_ff, int_en_ff;
   logic        fa_act_ff, fb_act_ff, fpu_ff;
   logic [2:0]  up_sync_ff, dn_sync_ff;
   logic        up_ff, dn_ff;
   logic        aw_hold_ff, w_hold_ff;
   logic [7:0]  aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   rd_state_t   rd_state_ff;

   //==========================================================
   // pin synchronisers: a change counts when stages two and three agree
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         up_sync_ff <= 3'h7;
         dn_sync_ff <= 3'h7;
         up_ff      <= 1'b1;
         dn_ff      <= 1'b1;
      end else begin
         up_sync_ff <= {up_sync_ff[1:0], shared_pin_2_in};  // R15
         dn_sync_ff <= {dn_sync_ff[1:0], shared_pin_3_in};  // R15
         if (up_sync_ff[1] == up_sync_ff[2]) begin
            up_ff <= up_sync_ff[2];
         end
         if (dn_sync_ff[1] == dn_sync_ff[2]) begin
            dn_ff <= dn_sync_ff[2];
         end
      end
   end

   //==========================================================
   // margin bank decode
   logic pin_marg, margin_en;
   assign pin_marg = mode_ff[`MODE_MARGIN_BIT] & (up_ff ^ dn_ff);
   assign margin_en = pin_marg | mode_ff[`MODE_SWMARG_BIT];

   always_comb begin
      if (!mode_ff[`MODE_MARGIN_BIT] || up_ff == dn_ff) begin
         dac_bank_out = BANK_NORMAL;                     // R12
      end else if (!up_ff) begin
         dac_bank_out = BANK_UP;                         // R10
      end else begin
         dac_bank_out = BANK_DOWN;                       // R11
      end
   end
   // switches close from the pins while the mode margin bit is set, no switch register needed
   assign dac_switch_force_out = pin_marg;               // R13 R14
   assign margin_active_out    = margin_en;              // R13
   assign log_inhibit_out      = margin_en;              // R16

   //==========================================================
   // fault state: frozen while margining so swept supplies do not trip
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fa_act_ff <= 1'b0;
         fb_act_ff <= 1'b0;
         fpu_ff    <= 1'b0;
      end else if (!margin_en) begin                     // R16
         fa_act_ff <= fault_hit(fa_sel_ff, fa_ctl_ff,
                                ov_viol_in, uv_viol_in, ew_viol_in);
         fb_act_ff <= fault_hit(fb_sel_ff, fb_ctl_ff,
                                ov_viol_in, uv_viol_in, ew_viol_in);
         fpu_ff    <= seq_fault_in & mode_ff[`MODE_FPU_BIT];  // R9
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fault_out_a_out <= 1'b1;
         fault_out_b_out <= 1'b1;
      end else begin
         fault_out_a_out <= pol_level(fa_act_ff, fa_ctl_ff[`CTL_POL_BIT]);
         fault_out_b_out <= pol_level(fb_act_ff, fb_ctl_ff[`CTL_POL_BIT]);
      end
   end

   // open drain flag: pull low on fault, enable low while driving
   assign powerup_fault_flag_out = 1'b0;
   assign powerup_fault_oe_n_out = ~fpu_ff;              // R9
   assign supply_disable_out     = fpu_ff;               // R9
   assign fault_store_out        = fpu_ff;               // R9

   //==========================================================
   // interrupt status: set wins over clear
   logic       clr_hit;
   logic [3:0] ev, clr_mask;
   assign ev = {margin_en, fpu_ff, fb_act_ff, fa_act_ff};
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_ff <= 4'h0;
      end else begin
         status_ff <= (status_ff & ~clr_mask) | ev;
      end
   end
   assign irq_out = |(status_ff & int_en_ff);

   //==========================================================
   // axi write: address and data taken in either order
   logic wr_go;
   assign awready_out = ~aw_hold_ff & ~bvalid_out;
   assign wready_out  = ~w_hold_ff & ~bvalid_out;
   assign wr_go       = aw_hold_ff & w_hold_ff & ~bvalid_out;
   assign bresp_out   = 2'h0;
   assign clr_hit  = wr_go && aw_addr_ff[7:2] == `REG_INT_CLR
                     && w_strb_ff[0];
   assign clr_mask = clr_hit ? w_data_ff[3:0] : 4'h0;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         bvalid_out <= 1'b0;
      end else begin
         if (awvalid_in && awready_out) begin
            aw_hold_ff <= 1'b1;
            aw_addr_ff <= awaddr_in;
         end
         if (wvalid_in && wready_out) begin
            w_hold_ff <= 1'b1;
            w_data_ff <= wdata_in;
            w_strb_ff <= wstrb_in;
         end
         if (wr_go) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_out <= 1'b1;
         end else if (bvalid_out && bready_in) begin
            bvalid_out <= 1'b0;
         end
      end
   end

   // register store, low byte lane only
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fa_sel_ff <= `REG_RESET;
         fa_ctl_ff <= `REG_RESET;
         fb_sel_ff <= `REG_RESET;
         fb_ctl_ff <= `REG_RESET;
         mode_ff   <= `REG_RESET;
         int_en_ff <= 4'h0;
      end else if (wr_go && w_strb_ff[0]) begin
         case (aw_addr_ff[7:2])
            `REG_FA_SEL: fa_sel_ff <= w_data_ff[7:0];   // R1
            `REG_FA_CTL: fa_ctl_ff <= w_data_ff[7:0];   // R2 R3 R4
            `REG_FB_SEL: fb_sel_ff <= w_data_ff[7:0];   // R5
            `REG_FB_CTL: fb_ctl_ff <= w_data_ff[7:0];   // R6 R7 R4
            `REG_MODE:   mode_ff   <= {5'h00, w_data_ff[2:0]};
            `REG_INT_EN: int_en_ff <= w_data_ff[3:0];
            default: ;
         endcase
      end
   end

   //==========================================================
   // axi read: one beat, answer the cycle after the address
   logic [31:0] rd_mux;
   always_comb begin
      case (araddr_in[7:2])
         `REG_FA_SEL: rd_mux = {24'h000000, fa_sel_ff};
         `REG_FA_CTL: rd_mux = {24'h000000, fa_ctl_ff};
         `REG_FB_SEL: rd_mux = {24'h000000, fb_sel_ff};
         `REG_FB_CTL: rd_mux = {24'h000000, fb_ctl_ff};
         `REG_MODE:   rd_mux = {24'h000000, mode_ff};
         `REG_STATUS: rd_mux = {28'h0000000, status_ff};
         `REG_INT_EN: rd_mux = {28'h0000000, int_en_ff};
         default:     rd_mux = 32'h0000_0000;
      endcase
   end
   logic rd_ok;
   always_comb begin
      case (araddr_in[7:2])
         `REG_FA_SEL, `REG_FA_CTL, `REG_FB_SEL, `REG_FB_CTL,
         `REG_MODE, `REG_STATUS, `REG_INT_EN: rd_ok = 1'b1;
         default: rd_ok = 1'b0;
      endcase
   end

   assign arready_out = (rd_state_ff == RD_IDLE);
   assign rvalid_out  = (rd_state_ff == RD_DATA);
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_state_ff <= RD_IDLE;
         rdata_out   <= 32'h0000_0000;
         rresp_out   <= 2'h0;
      end else begin
         case (rd_state_ff)
            RD_IDLE: begin
               if (arvalid_in) begin
                  rd_state_ff <= RD_DATA;
                  rdata_out   <= rd_mux;
                  rresp_out   <= rd_ok ? 2'h0 : 2'h2;
               end
            end
            RD_DATA: begin
               if (rready_in) begin
                  rd_state_ff <= RD_IDLE;
               end
            end
            default: rd_state_ff <= RD_IDLE;
         endcase
      end
   end

   //==========================================================
   // checks
   sequence s_cfg_a_hit;
      !margin_en && fault_hit(fa_sel_ff, fa_ctl_ff, ov_viol_in,
                              uv_viol_in, ew_viol_in);
   endsequence
   a_fault_a_assert: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R8
      s_cfg_a_hit ##1 !margin_en |=> fault_out_a_out == fa_ctl_ff[`CTL_POL_BIT])
      else $error("fault a not asserted");
   a_fault_a_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R17
      !fa_act_ff |=> fault_out_a_out == !$past(fa_ctl_ff[`CTL_POL_BIT]))
      else $error("fault a wrong idle level");
   a_fault_b_pol: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R4
      fb_act_ff |=> fault_out_b_out == $past(fb_ctl_ff[`CTL_POL_BIT]))
      else $error("fault b polarity wrong");
   a_margin_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R16
      margin_en |=> $stable(fa_act_ff) && $stable(fb_act_ff))
      else $error("fault state moved while margining");
   a_bank_up: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R10
      mode_ff[`MODE_MARGIN_BIT] && !up_ff && dn_ff |-> dac_bank_out == BANK_UP)
      else $error("up bank not chosen");
   a_bank_down: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R11
      mode_ff[`MODE_MARGIN_BIT] && up_ff && !dn_ff |-> dac_bank_out == BANK_DOWN)
      else $error("down bank not chosen");
   a_bank_normal: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R12
      up_ff == dn_ff |-> dac_bank_out == BANK_NORMAL && !dac_switch_force_out)
      else $error("normal bank not chosen");
   a_switch_close: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R13
      dac_bank_out != BANK_NORMAL |-> dac_switch_force_out && margin_active_out)
      else $error("switches not closed");
   a_fpu_flag: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R9
      seq_fault_in && mode_ff[`MODE_FPU_BIT] && !margin_en
      |=> !powerup_fault_oe_n_out && supply_disable_out)
      else $error("power-up fault not flagged");

endmodule

/* File: design/fault_margin_consts.svh */
// constants for the fault output and margin select block
//==========================================================
// Notes on behaviour
// (R1) fault A select bits 0..7 add monitored inputs 1..8 to output A.
// (R2) fault A control bits 3:0 add monitored inputs 9..12 (twelve-channel only).
// (R3) fault A control bits 4,5,6 enable overvoltage, undervoltage, early warning.
// (R4) control bit 7 sets polarity: zero asserts low, one asserts high.
// (R5) fault B select bits 0..7 add monitored inputs 1..8 to output B.
// (R6) fault B control bits 3:0 add monitored inputs 9..12 (twelve-channel only).
// (R7) fault B control bits 4,5,6 enable overvoltage, undervoltage, early warning.
// (R8) output asserts when any selected input violates any enabled threshold.
// (R9) power-up fault pin signals faults in sequencing, drives enables low, stores data.
// (R10) raise low and lower high selects the margin-up DAC bank.
// (R11) lower low and raise high selects the margin-down DAC bank.
// (R12) equal margin inputs select the normal DAC bank.
// (R13) an asserted margin input closes DAC switches and enables margining.
// (R14) software need not write switch-enable registers for pin margining.
// (R15) shared pin 2 is the raise input, shared pin 3 the lower input.
// (R16) while margining, fault outputs hold, violations ignored, logging skipped.
// (R17) no input selected or no class enabled keeps output deasserted.
`ifndef FAULT_MARGIN_CONSTS_SVH
`define FAULT_MARGIN_CONSTS_SVH
//==========================================================
// register indices; the byte address on the bus is index times four
`define REG_FA_SEL     6'h15
`define REG_FA_CTL     6'h16
`define REG_FB_SEL     6'h17
`define REG_FB_CTL     6'h18
`define REG_MODE       6'h19
`define REG_STATUS     6'h1A
`define REG_INT_CLR    6'h1B
`define REG_INT_EN     6'h1C
//==========================================================
// control fields
`define CTL_UPPER_MSB  3
`define CTL_OV_BIT     4
`define CTL_UV_BIT     5
`define CTL_EW_BIT     6
`define CTL_POL_BIT    7
`define MODE_MARGIN_BIT 0
`define MODE_FPU_BIT   1
`define MODE_SWMARG_BIT 2
`define ST_FA_BIT      0
`define ST_FB_BIT      1
`define ST_FPU_BIT     2
`define ST_MARG_BIT    3
`define REG_RESET      8'h00
`define NUM_MON        12
`define STATUS_W       4
`endif

/* File: design/fault_margin_pkg.sv */
// types for the fault output and margin select block
package fault_margin_pkg;
   typedef enum logic [2:0] {
      BANK_NORMAL = 3'b001,
      BANK_UP     = 3'b010,
      BANK_DOWN   = 3'b100
   } dac_bank_t;
   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_DATA = 3'b010,
      RD_XX   = 3'b100
   } rd_state_t;
endpackage

/* File: testbench/supervisor_model.sv */
// board-side partner: comparator flags, sequencer fault and margin pins
`timescale 1ns/100ps
module supervisor_model (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // commanded {ov, uv, ew, seq, raise, lower} and answer lag
   input  wire logic [38:0] cmd_in,
   input  wire logic [3:0]  lag_in,
   // flags toward the block
   output logic [11:0]      ov_out,
   output logic [11:0]      uv_out,
   output logic [11:0]      ew_out,
   output logic             seq_out,
   // margin pins, pulled up unless driven low
   output logic             pin2_out,
   output logic             pin3_out
);
   logic [38:0] cur_ff;
   logic [3:0]  wait_ff;

   // follow the command after lag_in cycles, so slow supplies are covered
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cur_ff  <= 39'h0;
         wait_ff <= 4'h0;
      end else if (cmd_in != cur_ff && wait_ff < lag_in) begin
         wait_ff <= wait_ff + 4'h1;
      end else begin
         cur_ff  <= cmd_in;
         wait_ff <= 4'h0;
      end
   end
   // comparator flags are levels in the block's own clock domain
   assign ov_out  = cur_ff[38:27];
   assign uv_out  = cur_ff[26:15];
   assign ew_out  = cur_ff[14:3];
   assign seq_out = cur_ff[2];
   // pins only; switch registers are never written from this side
   assign pin2_out = ~cur_ff[1];
   assign pin3_out = ~cur_ff[0];
endmodule

/* File: testbench/fault_output_margin_select_tb_top.sv */
// self-checking bench for the fault output and margin select block
`timescale 1ns/100ps
`include "fault_margin_consts.svh"
module fault_output_margin_select_tb_top
   import fault_margin_pkg::*;
;
   // design and partner signals
   logic        clk_in, arst_n_in, awvalid_in, awready_out, wvalid_in;
   logic        wready_out, bvalid_out, bready_in, arvalid_in, irq_out;
   logic        arready_out, rvalid_out, rready_in, seq_fault_in;
   logic        shared_pin_2_in, shared_pin_3_in, fault_out_a_out;
   logic        fault_out_b_out, powerup_fault_flag_out, log_inhibit_out;
   logic        powerup_fault_oe_n_out, supply_disable_out;
   logic        fault_store_out, dac_switch_force_out, margin_active_out;
   logic [7:0]  awaddr_in, araddr_in;
   logic [31:0] wdata_in, rdata_out, rd_word;
   logic [3:0]  wstrb_in, lag;
   logic [1:0]  bresp_out, rresp_out, rd_resp;
   logic [11:0] ov_viol_in, uv_viol_in, ew_viol_in;
   logic [38:0] cmd;
   dac_bank_t   dac_bank_out;
   int          err_count, num_checks;

   fault_margin_select dut_u (.clk_in, .arst_n_in, .awaddr_in, .awvalid_in,
      .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out,
      .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in,
      .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
      .ov_viol_in, .uv_viol_in, .ew_viol_in, .seq_fault_in,
      .shared_pin_2_in, .shared_pin_3_in, .fault_out_a_out,
      .fault_out_b_out, .powerup_fault_flag_out, .powerup_fault_oe_n_out,
      .supply_disable_out, .fault_store_out, .dac_bank_out,
      .dac_switch_force_out, .margin_active_out, .log_inhibit_out,
      .irq_out);
   supervisor_model sup_u (.clk_in, .arst_n_in, .cmd_in(cmd), .lag_in(lag),
      .ov_out(ov_viol_in), .uv_out(uv_viol_in), .ew_out(ew_viol_in),
      .seq_out(seq_fault_in), .pin2_out(shared_pin_2_in),
      .pin3_out(shared_pin_3_in));

   // 125 MHz clock
   initial begin
      clk_in = 1'h0;
      forever #4 clk_in = ~clk_in;
   end
   //==========================================================
   // shared tasks
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic give_up;
      $display("timeout at %0t", $time);
      err_count++;
      give_verdict();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bus write; valids and bready held until their own handshake edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      bit aw_done, w_done;
      aw_done = 0;
      w_done = 0;
      @(posedge clk_in);
      awaddr_in <= {a[5:0], 2'h0}; // index to byte address
      wdata_in <= d;
      wstrb_in <= 4'h1; // only lane 0 carries a register
      awvalid_in <= 1'h1;
      wvalid_in <= 1'h1;
      bready_in <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_in);
         if (aw_done && w_done && bvalid_out === 1'h1) break;
         if (!aw_done && awready_out === 1'h1) awvalid_in <= 1'h0;
         if (!aw_done && awready_out === 1'h1) aw_done = 1;
         if (!w_done && wready_out === 1'h1) wvalid_in <= 1'h0;
         if (!w_done && wready_out === 1'h1) w_done = 1;
      end
      bready_in <= 1'h0;
      if (n == 50) give_up();
      chk(bresp_out, 2'h0);
   endtask
   task automatic axi_rd(input logic [7:0] a);
      int n;
      bit got_a;
      got_a = 0;
      @(posedge clk_in);
      araddr_in <= {a[5:0], 2'h0}; // index to byte address
      arvalid_in <= 1'h1;
      rready_in <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_in);
         if (got_a && rvalid_out === 1'h1) break;
         if (!got_a && arready_out === 1'h1) arvalid_in <= 1'h0;
         if (!got_a && arready_out === 1'h1) got_a = 1;
      end
      rd_word = rdata_out;
      rd_resp = rresp_out;
      rready_in <= 1'h0;
      if (n == 50) give_up();
   endtask
   // fixed settle: partner lag, pin synchroniser and two-stage fault path
   task automatic set_cmd(input logic [38:0] c);
      @(posedge clk_in);
      cmd <= c;
      repeat (lag + 8) @(posedge clk_in);
   endtask
   function automatic logic [38:0] viol(int k, int i);
      return 39'h1 << (3 + 12 * (2 - k) + i);
   endfunction
   function automatic logic out_of(bit b);
      return b ? fault_out_b_out : fault_out_a_out;
   endfunction
   //==========================================================
   // scenarios
   task automatic t_regs;
      logic [7:0] adr [6] = '{`REG_FA_SEL, `REG_FA_CTL, `REG_FB_SEL,
                              `REG_FB_CTL, `REG_MODE, `REG_INT_EN};
      // mode keeps three bits, interrupt enable four
      logic [7:0] msk [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h0F};
      foreach (adr[j]) begin
         axi_rd(adr[j]);
         chk(rd_word, 32'h0);
         axi_wr(adr[j], {24'hA5C3E1, adr[j] ^ 8'h5A});
         axi_rd(adr[j]);
         chk(rd_word, {24'h0, (adr[j] ^ 8'h5A) & msk[j]});
         axi_wr(adr[j], 32'h0);
      end
      axi_rd(8'h30);
      chk({rd_resp, rd_word}, {2'h2, 32'h0});
      axi_wr(`REG_STATUS, 32'hFF);
      axi_rd(`REG_STATUS);
      chk(rd_word, 32'h0);
      $display("register test done");
   endtask
   // one input and one class per pass; wrong class or input must not count
   task automatic t_fault(input bit b, input logic pol);
      logic [11:0] m;
      logic [7:0]  sa, ca;
      sa = b ? `REG_FB_SEL : `REG_FA_SEL;
      ca = b ? `REG_FB_CTL : `REG_FA_CTL;
      for (int i = 0; i < 12; i++) begin
         m = 12'h1 << i;
         axi_wr(sa, {24'h0, m[7:0]});
         axi_wr(ca, {24'h0, pol, 3'h1 << (i % 3), m[11:8]});
         set_cmd(viol(i % 3, i));
         chk(out_of(b), pol);
         set_cmd(viol((i + 1) % 3, i) | viol(i % 3, (i + 1) % 12));
         chk(out_of(b), !pol);
         chk(out_of(!b), 1'h1);
      end
      axi_wr(sa, 32'hFF);
      axi_wr(ca, {24'h0, pol, 7'h7F});
      set_cmd(viol(2, 11));
      chk(out_of(b), pol);
      axi_wr(ca, {24'h0, pol, 7'h0F});
      set_cmd({36'hFFFFFFFFF, 3'h0});
      chk(out_of(b), !pol);
      set_cmd(39'h0);
      axi_wr(sa, 32'h0);
      axi_wr(ca, 32'h0);
      $display("fault routing test done");
   endtask
   task automatic t_margin;
      dac_bank_t exp_b [4] = '{BANK_NORMAL, BANK_DOWN, BANK_UP, BANK_NORMAL};
      lag = 4'h3;
      axi_wr(`REG_MODE, 32'h01);
      for (int p = 0; p < 4; p++) begin
         set_cmd({37'h0, p[1:0]});
         chk(dac_bank_out, exp_b[p]);
         chk({dac_switch_force_out, margin_active_out},
             {2{p == 1 || p == 2}});
      end
      axi_wr(`REG_FA_SEL, 32'h01);
      axi_wr(`REG_FA_CTL, 32'h10);
      set_cmd(39'h2);
      set_cmd(viol(0, 0) | 39'h2);
      chk({fault_out_a_out, log_inhibit_out}, 2'h3);
      set_cmd(viol(0, 0));
      chk(fault_out_a_out, 1'h0);
      set_cmd(39'h0);
      axi_wr(`REG_MODE, 32'h0);
      axi_wr(`REG_FA_CTL, 32'h0);
      lag = 4'h0;
      $display("margin test done");
   endtask
   task automatic t_fpu;
      set_cmd(39'h4);
      chk(powerup_fault_oe_n_out, 1'h1);
      axi_wr(`REG_MODE, 32'h02);
      // fault state follows the mode one edge after the write lands
      repeat (2) @(posedge clk_in);
      chk({powerup_fault_oe_n_out, powerup_fault_flag_out,
           supply_disable_out, fault_store_out}, 4'h3);
      set_cmd(39'h0);
      axi_wr(`REG_MODE, 32'h0);
      $display("power-up fault test done");
   endtask
   task automatic t_irq;
      axi_wr(`REG_INT_EN, 32'h01);
      axi_wr(`REG_FA_CTL, 32'h10);
      set_cmd(viol(0, 0));
      axi_rd(`REG_STATUS);
      chk({irq_out, rd_word[0]}, 2'h3);
      axi_wr(`REG_INT_EN, 32'h0);
      chk(irq_out, 1'h0);
      set_cmd(39'h0);
      axi_wr(`REG_INT_EN, 32'h01);
      chk(irq_out, 1'h1);
      axi_wr(`REG_INT_CLR, 32'h01);
      axi_rd(`REG_STATUS);
      chk({irq_out, rd_word[0]}, 2'h0);
      $display("interrupt test done");
   endtask
   //==========================================================
   // main sequence
   initial begin
      err_count = 0;
      num_checks = 0;
      arst_n_in = 1'h0;
      {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h0;
      {awaddr_in, araddr_in, wdata_in, wstrb_in} = 52'h0;
      cmd = 39'h0;
      lag = 4'h0;
      repeat (2) @(posedge clk_in);
      chk({fault_out_a_out, fault_out_b_out, powerup_fault_oe_n_out,
           irq_out, dac_bank_out}, {4'hE, BANK_NORMAL});
      arst_n_in <= 1'h1;
      t_regs();
      t_fault(0, 1'h0);
      t_fault(1, 1'h1);
      t_fault(0, 1'h1);
      t_fault(1, 1'h0);
      t_margin();
      t_fpu();
      t_irq();
      give_verdict();
   end
endmodule
